// >>> rtl/kse_keypad_scan_engine.sv
// Keypad matrix scanner: row drive, column debounce, key latch, sleep.
// Assumes register requests already decoded from the host serial port,
// columns pulled up outside, and a column read low when a key on the driven row is pressed.
`timescale 1ns/1ps
module kse_keypad_scan_engine #(
	parameter int DEB_BASE_CYC = kse_pkg::KSE_DEB_BASE_CYC,
	parameter int SCAN_BASE_CYC = kse_pkg::KSE_SCAN_BASE_CYC,
	parameter int SLEEP_BASE_CYC = kse_pkg::KSE_SLEEP_BASE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire kse_pkg::kse_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic [7:0] row_out,
	output logic [7:0] row_oe_n,
	input wire logic [7:0] col_in,
	output logic interrupt_out_n,
	output logic interrupt_oe_n
);

	localparam int W = kse_pkg::KSE_CNT_W;
	localparam logic [W-1:0] DEB_B = W'(DEB_BASE_CYC);
	localparam logic [W-1:0] SCAN_B = W'(SCAN_BASE_CYC);
	localparam logic [W-1:0] SLEEP_B = W'(SLEEP_BASE_CYC);

	logic [7:0] deb_time_q;
	logic [7:0] deb_en_q;
	logic [7:0] sleep_scan_q;
	logic [7:0] matrix_q;
	logic [7:0] col_hit_q;
	logic [7:0] row_hit_q;
	logic [7:0] col_s1_q;
	logic [7:0] col_s2_q;
	logic [7:0] col_deb_q;
	logic [W-1:0] deb_cnt_q [8];
	kse_pkg::kse_state_t state_q;
	logic [2:0] row_q;
	logic [W-1:0] row_cnt_q;
	logic [W-1:0] idle_cnt_q;

	logic [2:0] rows_code;
	logic [2:0] cols_code;
	logic [2:0] sleep_code;
	logic [W-1:0] deb_dur;
	logic [W-1:0] scan_dur;
	logic [W-1:0] sleep_dur;
	logic [7:0] col_low;
	logic row_end;
	logic row_read;

	assign rows_code = matrix_q[kse_pkg::KSE_ROWS_LSB +: 3];
	assign cols_code = matrix_q[kse_pkg::KSE_COLS_LSB +: 3];
	assign sleep_code = sleep_scan_q[kse_pkg::KSE_SLEEP_LSB +: 3];
	assign deb_dur = kse_pkg::kse_dur(DEB_B, deb_time_q[2:0]);
	assign scan_dur =
		kse_pkg::kse_dur(SCAN_B, sleep_scan_q[kse_pkg::KSE_SCAN_LSB +: 3]);
	assign sleep_dur = kse_pkg::kse_dur(SLEEP_B, sleep_code - 3'h1);
	assign col_low = ~col_deb_q & kse_pkg::kse_mask(cols_code);
	assign row_end = row_cnt_q >= scan_dur - W'(1);
	assign row_read = reg_req.rd && reg_req.addr == kse_pkg::KSE_ADDR_ROW_HIT;

	// Configuration registers
	always_ff @(posedge clk) begin
		if (rst) begin
			deb_time_q <= kse_pkg::KSE_RST_CFG;
			deb_en_q <= kse_pkg::KSE_RST_CFG;
			sleep_scan_q <= kse_pkg::KSE_RST_CFG;
			matrix_q <= kse_pkg::KSE_RST_CFG;
		end else if (reg_req.wr) begin
			case (reg_req.addr)
				kse_pkg::KSE_ADDR_DEB_TIME: deb_time_q <= reg_req.wdata;
				kse_pkg::KSE_ADDR_DEB_EN_A: deb_en_q <= reg_req.wdata;
				kse_pkg::KSE_ADDR_SLEEP_SCAN: sleep_scan_q <= reg_req.wdata;
				kse_pkg::KSE_ADDR_MATRIX: matrix_q <= reg_req.wdata;
				default: ;
			endcase
		end
	end

	// Read data
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.rd) begin
			case (reg_req.addr)
				kse_pkg::KSE_ADDR_DEB_TIME: reg_rdata <= deb_time_q;
				kse_pkg::KSE_ADDR_DEB_EN_A: reg_rdata <= deb_en_q;
				kse_pkg::KSE_ADDR_SLEEP_SCAN: reg_rdata <= sleep_scan_q;
				kse_pkg::KSE_ADDR_MATRIX: reg_rdata <= matrix_q;
				kse_pkg::KSE_ADDR_COL_HIT: reg_rdata <= col_hit_q;
				kse_pkg::KSE_ADDR_ROW_HIT: reg_rdata <= row_hit_q;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Column pins cross in through two flops
	always_ff @(posedge clk) begin
		if (rst) begin
			col_s1_q <= 8'hFF;
			col_s2_q <= 8'hFF;
		end else begin
			col_s1_q <= col_in;
			col_s2_q <= col_s1_q;
		end
	end

	// Per-column debounce; disabled bits pass straight through
	always_ff @(posedge clk) begin
		if (rst) begin
			col_deb_q <= 8'hFF;
			for (int i = 0; i < 8; i++) begin
				deb_cnt_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (!deb_en_q[i] || col_s2_q[i] == col_deb_q[i]) begin
					col_deb_q[i] <= col_s2_q[i];
					deb_cnt_q[i] <= '0;
				end else if (deb_cnt_q[i] >= deb_dur - W'(1)) begin
					col_deb_q[i] <= col_s2_q[i];
					deb_cnt_q[i] <= '0;
				end else begin
					deb_cnt_q[i] <= deb_cnt_q[i] + W'(1);
				end
			end
		end
	end

	// Scan sequencer. While scanning, columns are judged only at the end of a row slot,
	// so a debounced level left over from the previous row cannot leak while the debounce time is at least four cycles shorter than the slot.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= kse_pkg::KSE_OFF;
			row_q <= 3'h0;
			row_cnt_q <= '0;
			idle_cnt_q <= '0;
		end else if (rows_code == 3'h0) begin
			state_q <= kse_pkg::KSE_OFF;
			row_q <= 3'h0;
			row_cnt_q <= '0;
			idle_cnt_q <= '0;
		end else begin
			case (state_q)
				kse_pkg::KSE_OFF: begin
					state_q <= kse_pkg::KSE_SCAN;
				end
				kse_pkg::KSE_SCAN: begin
					row_cnt_q <= row_end ? '0 : row_cnt_q + W'(1);
					idle_cnt_q <= idle_cnt_q + W'(1);
					if (row_end && col_low != 8'h00) begin
						state_q <= kse_pkg::KSE_HOLD;
					end else if (sleep_code != 3'h0 &&
						idle_cnt_q >= sleep_dur - W'(1)) begin
						state_q <= kse_pkg::KSE_SLEEP;
					end else if (row_end) begin
						row_q <= (row_q >= rows_code) ? 3'h0 : row_q + 3'h1;
					end
				end
				kse_pkg::KSE_HOLD: begin
					if (row_read) begin
						state_q <= kse_pkg::KSE_SCAN;
						row_q <= (row_q >= rows_code) ? 3'h0 : row_q + 3'h1;
						row_cnt_q <= '0;
						idle_cnt_q <= '0;
					end
				end
				kse_pkg::KSE_SLEEP: begin
					// Wake on any key in the enabled columns with all enabled rows pulled low
					if (col_low != 8'h00) begin
						state_q <= kse_pkg::KSE_SCAN;
						row_q <= 3'h0;
						row_cnt_q <= '0;
						idle_cnt_q <= '0;
					end
				end
				default: state_q <= kse_pkg::KSE_OFF;
			endcase
		end
	end

	// Key data and interrupt; a latch can only happen while scanning,
	// and it wins over a clearing read that lands in the same cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			col_hit_q <= kse_pkg::KSE_RST_HIT;
			row_hit_q <= kse_pkg::KSE_RST_HIT;
			interrupt_out_n <= 1'b1;
			interrupt_oe_n <= 1'b1;
		end else if (state_q == kse_pkg::KSE_SCAN && rows_code != 3'h0 &&
			row_end && col_low != 8'h00) begin
			col_hit_q <= ~col_low;
			row_hit_q <= ~(8'h01 << row_q);
			interrupt_out_n <= 1'b0;
			interrupt_oe_n <= 1'b0;
		end else if (row_read) begin
			col_hit_q <= kse_pkg::KSE_RST_HIT;
			row_hit_q <= kse_pkg::KSE_RST_HIT;
			interrupt_out_n <= 1'b1;
			interrupt_oe_n <= 1'b1;
		end
	end

	// Row drive: in scan and hold, active row low, other enabled rows high; sleep pulls all enabled rows low; rest released
	always_ff @(posedge clk) begin
		if (rst) begin
			row_out <= 8'hFF;
			row_oe_n <= 8'hFF;
		end else begin
			case (state_q)
				kse_pkg::KSE_SCAN, kse_pkg::KSE_HOLD: begin
					row_out <= ~(8'h01 << row_q);
					row_oe_n <= ~kse_pkg::kse_mask(rows_code);
				end
				kse_pkg::KSE_SLEEP: begin
					row_out <= 8'h00;
					row_oe_n <= ~kse_pkg::kse_mask(rows_code);
				end
				default: begin
					row_out <= 8'hFF;
					row_oe_n <= 8'hFF;
				end
			endcase
		end
	end

endmodule : kse_keypad_scan_engine

// >>> rtl/kse_pkg.sv
// Constants, field layouts and carrier types of the keypad scan engine.
// Assumes a single 2 MHz clock and a decoded register port.
package kse_pkg;

	localparam logic [7:0] KSE_ADDR_DEB_TIME = 8'h22;
	localparam logic [7:0] KSE_ADDR_DEB_EN_A = 8'h24;
	localparam logic [7:0] KSE_ADDR_SLEEP_SCAN = 8'h25;
	localparam logic [7:0] KSE_ADDR_MATRIX = 8'h26;
	localparam logic [7:0] KSE_ADDR_COL_HIT = 8'h27;
	localparam logic [7:0] KSE_ADDR_ROW_HIT = 8'h28;

	localparam logic [7:0] KSE_RST_CFG = 8'h00;
	localparam logic [7:0] KSE_RST_HIT = 8'hFF;

	localparam int KSE_SLEEP_LSB = 4;
	localparam int KSE_SCAN_LSB = 0;
	localparam int KSE_ROWS_LSB = 3;
	localparam int KSE_COLS_LSB = 0;

	// Scaled times are counted in 2 MHz reference ticks of the oscillator
	localparam int KSE_REF_KHZ = 2000;
	localparam int KSE_DEB_BASE_US = 500;
	localparam int KSE_SCAN_BASE_US = 1000;
	localparam int KSE_SLEEP_BASE_US = 128000;
	localparam int KSE_DEB_BASE_CYC = KSE_DEB_BASE_US * KSE_REF_KHZ / 1000;
	localparam int KSE_SCAN_BASE_CYC = KSE_SCAN_BASE_US * KSE_REF_KHZ / 1000;
	localparam int KSE_SLEEP_BASE_CYC =
		KSE_SLEEP_BASE_US * KSE_REF_KHZ / 1000;

	localparam int KSE_CNT_W = 24;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} kse_reg_req_t;

	typedef enum logic [1:0] {
		KSE_OFF,
		KSE_SCAN,
		KSE_HOLD,
		KSE_SLEEP
	} kse_state_t;

	// Base duration doubled per code step
	function automatic logic [KSE_CNT_W-1:0] kse_dur(
		input logic [KSE_CNT_W-1:0] base,
		input logic [2:0] code);
		kse_dur = base << code;
	endfunction : kse_dur

	// Low n+1 bits set
	function automatic logic [7:0] kse_mask(input logic [2:0] code);
		kse_mask = 8'hFF >> (3'h7 - code);
	endfunction : kse_mask

endpackage : kse_pkg

// >>> test/kse_checker.sv
// Port checks of the keypad scan engine.
// Assumes a bind onto the engine top.
`timescale 1ns/1ps
module kse_checker (
	input wire logic clk,
	input wire logic rst,
	input wire kse_pkg::kse_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] row_out,
	input wire logic [7:0] row_oe_n,
	input wire logic [7:0] col_in,
	input wire logic interrupt_out_n,
	input wire logic interrupt_oe_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	wire logic rd_row = reg_req.rd && reg_req.addr == 8'h28;
	wire logic rd_col = reg_req.rd && reg_req.addr == 8'h27;
	sequence s_hold;
		!interrupt_out_n && !rd_row;
	endsequence
	sequence s_clear;
		rd_row ##1 interrupt_out_n;
	endsequence
	a_pin_enable: assert property (
		interrupt_oe_n == interrupt_out_n) else $error("int enable");
	// A key latched in the cycle of the read wins; a held key must clear
	a_read_release: assert property (
		rd_row && !interrupt_out_n |-> s_clear) else $error("int kept");
	a_int_holds: assert property (s_hold |=> !interrupt_out_n)
		else $error("int lost");
	a_scan_halt: assert property (s_hold |=> $stable(row_out))
		else $error("rows moved");
	a_row_idle: assert property (rd_row && interrupt_out_n |=>
		reg_rdata == 8'hFF) else $error("row data");
	a_col_idle: assert property (rd_col && interrupt_out_n |=>
		reg_rdata == 8'hFF) else $error("col data");
	// Two sync flops, the debounce flop, then the latch itself
	a_key_cause: assert property ($fell(interrupt_out_n) |->
		$past(col_in, 4) != 8'hFF) else $error("no key");
	a_reset_off: assert property (disable iff (1'b0) rst |=>
		interrupt_out_n && row_oe_n == 8'hFF) else $error("reset");
endmodule : kse_checker

// >>> test/kse_key_matrix.sv
// Key matrix model: one closed key at a time.
// Assumes pulled-up columns, rows active low.
`timescale 1ns/1ps
module kse_key_matrix (
	input wire logic [7:0] row_out,
	input wire logic [7:0] row_oe_n,
	input wire logic key_on,
	input wire logic [2:0] key_row,
	input wire logic [2:0] key_col,
	output logic [7:0] col_in
);
	// Released rows never pull a column low
	always_comb begin
		col_in = 8'hFF;
		if (key_on && !row_oe_n[key_row] && !row_out[key_row]) begin
			col_in[key_col] = 1'b0;
		end
	end
endmodule : kse_key_matrix

// >>> test/test_keypad_scan_engine.sv
// Bench of the keypad scan engine with a key matrix.
// Assumes small base counts: 4, 8 and 64 cycles.
`timescale 1ns/1ps
module test_keypad_scan_engine;
	logic clk = 1'b0;
	logic rst = 1'b1;
	kse_pkg::kse_reg_req_t reg_req = '0;
	logic [7:0] reg_rdata, row_out, row_oe_n, col_in, v;
	logic interrupt_out_n, interrupt_oe_n;
	logic key_on = 1'b0;
	logic [2:0] key_row = 3'h0;
	logic [2:0] key_col = 3'h0;
	int n_fail = 0;
	int n_checks = 0;
	kse_keypad_scan_engine #(.DEB_BASE_CYC(4), .SCAN_BASE_CYC(8),
		.SLEEP_BASE_CYC(64)) kse_keypad_scan_engine_inst (.clk(clk),
		.rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.row_out(row_out), .row_oe_n(row_oe_n), .col_in(col_in),
		.interrupt_out_n(interrupt_out_n),
		.interrupt_oe_n(interrupt_oe_n));
	kse_key_matrix kse_key_matrix_inst (.row_out(row_out),
		.row_oe_n(row_oe_n), .key_on(key_on), .key_row(key_row),
		.key_col(key_col), .col_in(col_in));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask : check
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk);
		reg_req = '0;
		v = reg_rdata;
	endtask : acc
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle
	task automatic t_regs();
		for (int i = 0; i < 5; i++) begin
			acc(1'b1, 8'h24 + 8'(i), 8'h12);
			acc(1'b0, 8'h24 + 8'(i), 8'h00);
			check(v, i < 3 ? 8'h12 : 8'hFF);
			acc(1'b1, 8'h24 + 8'(i), 8'h00);
		end
		acc(1'b0, 8'h30, 8'h00);
		check(v, 8'h00);
		$display("regs done");
	endtask : t_regs
	task automatic t_scan();
		int n;
		for (int k = 0; k < 2; k++) begin
			v = row_out;
			n = 0;
			while (row_out === v && n < 99) begin
				idle(1);
				n++;
			end
		end
		check(8'(n), 8'h10);
		$display("scan done");
	endtask : t_scan
	task automatic t_key(input logic [2:0] rw, cl, r, c, input logic [7:0] d);
		int n = 0;
		logic hit;
		acc(1'b1, 8'h24, d);
		acc(1'b1, 8'h25, 8'h01);
		acc(1'b1, 8'h26, {2'b00, rw, cl});
		idle(3);
		// Row code zero leaves every row released
		check(row_oe_n, rw == 3'h0 ? 8'hFF : 8'hFF << (rw + 1));
		if (rw == 3'h1) begin
			t_scan();
		end
		key_row = r;
		key_col = c;
		key_on = 1'b1;
		while (interrupt_out_n !== 1'b0 && n < 300) begin
			idle(1);
			n++;
		end
		key_on = 1'b0;
		hit = c <= cl && rw != 3'h0;
		acc(1'b0, 8'h27, 8'h00);
		check(v, hit ? ~(8'h01 << c) : 8'hFF);
		acc(1'b0, 8'h28, 8'h00);
		check(v, hit ? ~(8'h01 << r) : 8'hFF);
		check({7'h00, interrupt_out_n}, 8'h01);
		acc(1'b0, 8'h27, 8'h00);
		check(v, 8'hFF);
		acc(1'b1, 8'h26, 8'h00);
		$display("key done");
	endtask : t_key
	// Sleep after idle time, wake on a key, then latch it on its row
	task automatic t_sleep();
		int n = 0;
		acc(1'b1, 8'h22, 8'h01);
		acc(1'b0, 8'h22, 8'h00);
		check(v, 8'h01);
		acc(1'b1, 8'h24, 8'h01);
		acc(1'b1, 8'h25, 8'h11);
		acc(1'b1, 8'h26, 8'h08);
		idle(80);
		check(row_out, 8'h00);
		check(row_oe_n, 8'hFC);
		key_row = 3'h1;
		key_col = 3'h0;
		key_on = 1'b1;
		while (interrupt_out_n !== 1'b0 && n < 300) begin
			idle(1);
			n++;
		end
		key_on = 1'b0;
		acc(1'b0, 8'h27, 8'h00);
		check(v, 8'hFE);
		acc(1'b0, 8'h28, 8'h00);
		check(v, 8'hFD);
		check({7'h00, interrupt_out_n}, 8'h01);
		acc(1'b1, 8'h26, 8'h00);
		acc(1'b1, 8'h25, 8'h01);
		acc(1'b1, 8'h22, 8'h00);
		$display("sleep done");
	endtask : t_sleep
	task automatic end_sim();
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		idle(3);
		rst = 1'b0;
		t_regs();
		t_key(3'h7, 3'h7, 3'h7, 3'h7, 8'h00);
		t_key(3'h1, 3'h0, 3'h1, 3'h0, 8'hFF);
		t_key(3'h3, 3'h2, 3'h0, 3'h2, 8'h04);
		// Column outside the matrix must never raise a key
		t_key(3'h1, 3'h0, 3'h0, 3'h5, 8'h00);
		t_key(3'h0, 3'h7, 3'h0, 3'h0, 8'h00);
		t_sleep();
		end_sim();
	end
	initial begin
		#500000;
		n_fail++;
		end_sim();
	end
endmodule : test_keypad_scan_engine
bind kse_keypad_scan_engine kse_checker kse_checker_inst (.clk(clk),
	.rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.row_out(row_out), .row_oe_n(row_oe_n), .col_in(col_in),
	.interrupt_out_n(interrupt_out_n), .interrupt_oe_n(interrupt_oe_n));
